// ### hw/sih_pkg.sv
// shared constants and carrier types for the status interrupt hierarchy
package sih_pkg;
   // ----------------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------------
   localparam int N_SRC       = 8;   // latched bits per source register
   localparam int N_GLB       = 4;   // global status registers
   localparam int N_XSR       = 9;   // transceiver status registers
   localparam int XSR_W       = 8;   // transceiver status register width
   // ----------------------------------------------------------------------
   // global register window
   // ----------------------------------------------------------------------
   localparam logic [7:0] GLB_BASE = 8'hf0;
   localparam logic [7:0] GLB_LAST = 8'hff;
   // ----------------------------------------------------------------------
   // field positions inside the second transceiver status register
   // ----------------------------------------------------------------------
   localparam int XSR2_IDX       = 1;  // index of the second register
   localparam int XSR2_LOS_BIT   = 0;  // loss of sync, condition
   localparam int XSR2_SYNC_BIT  = 4;  // sync regained, event
   // ----------------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------------
   localparam logic [N_SRC-1:0] SRC_RST  = 8'h00;
   localparam logic [XSR_W-1:0] XSR_RST  = 8'h00;
   localparam logic [N_GLB-1:0] GEN_RST  = 4'h0;

   // one global group: source set pulses and their per-bit enables
   typedef struct packed {
      logic [N_SRC-1:0] set;     // one-cycle event pulses
      logic [N_SRC-1:0] enable;  // per-bit interrupt enables
   } sih_src_t;

   // one transceiver register write-then-read access
   typedef struct packed {
      logic             wr;      // write strobe, refreshes the bits that data selects
      logic             rd;      // read strobe
      logic [3:0]       sel;     // register index 0..8
      logic [XSR_W-1:0] data;    // bits to refresh
   } sih_xacc_t;
endpackage

// ### hw/sih_top.sv
// status and interrupt aggregation with transceiver status registers
// ------------------------------------------------------------------------
// What this block does
// - global status follows enabled latched bits live
// - writing one clears that latched bit
// - enable one lets latched bit propagate
// - enabled latched bits feed global status
// - disabled bits still latch for polling
// - control bit picks driven or released idle
// - reading latched register clears whole register
// - no interrupts while any reset active
// - zero global enables block all mapper interrupts, not transceiver ones
// - all latched read clears status and the mapper part of irq, transceiver irq stays
// - info registers show interrupting transceiver registers
// - transceiver status bits latch on event
// - event bit clears on refresh write, waits recurrence
// - condition bit stays set while alarm present
// - write ones refresh readable bits, zeros hold
// - double bits interrupt on set and clear
// - register two bit0 loss, bit4 regain
// - global register window f0h to ffh, kept as constants only
// - soft reset bit sticks until pin or zero
// ------------------------------------------------------------------------
`timescale 1ns/1ps
module sih_top (
   // clock and reset
   input  wire logic                                   I_CORE_CLK,
   input  wire logic                                   I_ARST_N,
   // soft reset control and transceiver reset pin
   input  wire logic                                   I_SOFT_RST_WR,
   input  wire logic                                   I_SOFT_RST_VAL,
   input  wire logic                                   I_XCVR_RST_PIN,
   // mapper latched sources, one group per global register
   input  wire sih_pkg::sih_src_t  [sih_pkg::N_GLB-1:0] I_SRC,
   input  wire logic  [sih_pkg::N_GLB-1:0]             I_SRC_RD,
   input  wire logic  [sih_pkg::N_GLB-1:0][7:0]        I_SRC_W1C,
   input  wire logic  [sih_pkg::N_GLB-1:0]             I_GLOBAL_IRQ_ENABLE,
   input  wire logic                                   I_IRQ_IDLE_DRIVE_SELECT,
   // transceiver status sources and access
   input  wire logic  [sih_pkg::N_XSR-1:0][7:0]        I_XSR_EVENT,
   input  wire logic  [sih_pkg::N_XSR-1:0][7:0]        I_XSR_COND,
   input  wire logic  [sih_pkg::N_XSR-1:0][7:0]        I_XSR_IS_COND,
   input  wire logic  [sih_pkg::N_XSR-1:0][7:0]        I_XSR_DOUBLE,
   input  wire logic  [sih_pkg::N_XSR-1:0][7:0]        I_XSR_ENABLE,
   input  wire sih_pkg::sih_xacc_t                     I_XACC,
   input  wire logic                                   I_RX_SYNC_LOSS_FLAG,
   // status outputs
   output logic [sih_pkg::N_GLB-1:0][7:0]              O_SRC_LATCHED,
   output logic [sih_pkg::N_GLB-1:0]                   O_GLOBAL_IRQ_STATUS,
   output logic [7:0]                                  O_XSR_READ,
   output logic [7:0]                                  O_XCVR_IRQ_INFO_ONE,
   output logic [7:0]                                  O_XCVR_IRQ_INFO_TWO,
   output logic                                        O_SOFT_RST,
   // interrupt pin, open drain or push pull
   output logic                                        O_IRQ_N_OUT,
   output logic                                        O_IRQ_N_OE
);
   localparam int NG = sih_pkg::N_GLB;
   localparam int NX = sih_pkg::N_XSR;

   // ----------------------------------------------------------------------
   // synchronisers for pin inputs
   // ----------------------------------------------------------------------
   logic xpin_s1, xpin_s2, los_s1, los_s2, los_d;

   // transceiver reset pin and loss of sync pass two flops
   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         xpin_s1 <= 1'b0;
         xpin_s2 <= 1'b0;
         los_s1  <= 1'b0;
         los_s2  <= 1'b0;
         los_d   <= 1'b0;
      end else begin
         xpin_s1 <= I_XCVR_RST_PIN;
         xpin_s2 <= xpin_s1;
         los_s1  <= I_RX_SYNC_LOSS_FLAG;
         los_s2  <= los_s1;
         los_d   <= los_s2;
      end
   end

   // ----------------------------------------------------------------------
   // soft reset bit
   // ----------------------------------------------------------------------
   logic soft_rst, next_soft_rst, any_rst;

   always_comb begin
      next_soft_rst = soft_rst;
      if (I_SOFT_RST_WR) begin
         next_soft_rst = I_SOFT_RST_VAL;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         soft_rst <= 1'b0;   // pin reset forces zero
      end else begin
         soft_rst <= next_soft_rst;
      end
   end

   assign any_rst    = soft_rst | xpin_s2;
   assign O_SOFT_RST = soft_rst;

   // ----------------------------------------------------------------------
   // mapper latched status and global aggregation
   // ----------------------------------------------------------------------
   logic [NG-1:0][7:0] lat, next_lat;
   logic [NG-1:0]      gstat;

   // global window kept as package constants, no decode without a bus

   always_comb begin
      for (int g = 0; g < NG; g++) begin
         next_lat[g] = lat[g];
         if (I_SRC_RD[g]) begin
            next_lat[g] = 8'h00;
         end
         next_lat[g] = next_lat[g] & ~I_SRC_W1C[g];
         // set wins over read and write-one clears
         next_lat[g] = next_lat[g] | I_SRC[g].set;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         lat <= '0;
      end else if (soft_rst) begin
         lat <= '0;
      end else begin
         lat <= next_lat;
      end
   end

   always_comb begin
      for (int g = 0; g < NG; g++) begin
         gstat[g] = |(lat[g] & I_SRC[g].enable);
      end
   end

   assign O_SRC_LATCHED       = lat;
   assign O_GLOBAL_IRQ_STATUS = gstat;

   // ----------------------------------------------------------------------
   // transceiver status registers
   // ----------------------------------------------------------------------
   logic [NX-1:0][7:0] xsr, next_xsr, xrd, next_xrd, xcond, xcond_d;
   logic [NX-1:0][7:0] xevt;
   logic [NX-1:0]      xirq;
   logic [7:0]         xread, next_xread;

   // condition levels, register two bit0 from the loss of sync pin
   always_comb begin
      xcond = I_XSR_COND;
      xevt  = I_XSR_EVENT;
      xcond[sih_pkg::XSR2_IDX][sih_pkg::XSR2_LOS_BIT]  = los_s2;
      xevt[sih_pkg::XSR2_IDX][sih_pkg::XSR2_SYNC_BIT]  = los_d & ~los_s2;
   end

   always_comb begin
      for (int r = 0; r < NX; r++) begin
         next_xsr[r] = xsr[r];
         next_xrd[r] = xrd[r];
         if (I_XACC.wr && I_XACC.sel == 4'(r)) begin
            next_xrd[r] = (xrd[r] & ~I_XACC.data) | (xsr[r] & I_XACC.data);
            next_xsr[r] = (xsr[r] & ~I_XACC.data) | (xcond[r] & I_XACC.data);
         end
         next_xsr[r] = next_xsr[r] | xevt[r] | xcond[r];
         // double bits latch on falling edge too
         next_xsr[r] = next_xsr[r] | (I_XSR_DOUBLE[r] & xcond_d[r] & ~xcond[r]);
      end
      next_xread = xread;
      if (I_XACC.rd && I_XACC.sel < 4'(NX)) begin
         next_xread = xrd[I_XACC.sel];
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         xsr     <= '0;
         xrd     <= '0;
         xcond_d <= '0;
         xread   <= sih_pkg::XSR_RST;
      end else if (xpin_s2) begin
         xsr     <= '0;
         xrd     <= '0;
         xcond_d <= '0;
         xread   <= sih_pkg::XSR_RST;
      end else begin
         xsr     <= next_xsr;
         xrd     <= next_xrd;
         xcond_d <= xcond;
         xread   <= next_xread;
      end
   end

   always_comb begin
      for (int r = 0; r < NX; r++) begin
         xirq[r] = |(xsr[r] & I_XSR_ENABLE[r]);
      end
   end

   assign O_XCVR_IRQ_INFO_ONE = xirq[7:0];
   assign O_XCVR_IRQ_INFO_TWO = {7'h00, xirq[8]};
   assign O_XSR_READ          = xread;

   // ----------------------------------------------------------------------
   // interrupt pin
   // ----------------------------------------------------------------------
   logic irq, next_irq;

   always_comb begin
      next_irq = (|(gstat & I_GLOBAL_IRQ_ENABLE) | (|xirq)) & ~any_rst;
   end

   always_ff @(posedge I_CORE_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq;
      end
   end

   assign O_IRQ_N_OUT = ~irq;
   assign O_IRQ_N_OE  = irq | I_IRQ_IDLE_DRIVE_SELECT;

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   sequence s_rst_seen;
      any_rst;
   endsequence

   // enabled set pulse on group two, its enable held into the next cycle
   sequence s_enabled_set;
      (!soft_rst && (I_SRC[2].set & I_SRC[2].enable) != 8'h00) ##1 $stable(I_SRC[2].enable);
   endsequence

   a_reset_silences: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      s_rst_seen |=> !irq) else $error("irq raised during reset");

   a_enable_gates_irq: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      (!any_rst && (gstat & I_GLOBAL_IRQ_ENABLE) != '0) |=> irq)
      else $error("enabled status gave no irq");

   a_global_block: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      (I_GLOBAL_IRQ_ENABLE == '0 && xirq == '0) |=> !irq)
      else $error("irq despite zero global enables");

   a_read_clears: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      (I_SRC_RD[0] && !soft_rst) |=> ((lat[0] & ~$past(I_SRC[0].set)) == 8'h00))
      else $error("read left latched bits");

   a_w1c_clears: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      (!soft_rst && I_SRC_W1C[0][0] && !I_SRC[0].set[0]) |=> !lat[0][0])
      else $error("write one did not clear");

   a_latch_disabled: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      (!soft_rst && I_SRC[1].set[0]) |=> lat[1][0])
      else $error("bit did not latch");

   a_gstat_live: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      s_enabled_set |-> gstat[2]) else $error("global status missed enabled set");

   a_soft_sticks: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      (soft_rst && !I_SOFT_RST_WR) |=> soft_rst) else $error("soft reset dropped");

   a_idle_drive: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      (!irq) |-> (O_IRQ_N_OE == I_IRQ_IDLE_DRIVE_SELECT))
      else $error("idle drive wrong");

   a_sync_regain: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      (!xpin_s2 && los_d && !los_s2) |=> xsr[1][4]) else $error("regain not latched");

   a_double_clear: assert property (
      @(posedge I_CORE_CLK) disable iff (!I_ARST_N)
      (!xpin_s2 && I_XSR_DOUBLE[8][2] && xcond_d[8][2] && !xcond[8][2]) |=> xsr[8][2])
      else $error("double bit missed the clear");
endmodule

// ### testbench/sih_host_model.sv
// host model: transceiver status write-then-read accesses
`timescale 1ns/1ps
module sih_host_model (
   // clock
   input  wire logic          i_clk,
   // access to the block
   output sih_pkg::sih_xacc_t o_acc
);
   initial o_acc = '0;
   // ----------------------------------------------------------------------
   // access task
   // ----------------------------------------------------------------------
   // refresh write then read
   task automatic access(input logic [3:0] sel, input logic [7:0] mask);
      @(negedge i_clk);
      o_acc = '{wr: 1'b1, rd: 1'b0, sel: sel, data: mask};
      @(negedge i_clk);
      o_acc.wr = 1'b0;
      o_acc.rd = 1'b1;
      @(negedge i_clk);
      o_acc.rd = 1'b0;
      o_acc.data = ~mask; // released bus no longer shows the mask
   endtask
endmodule

// ### testbench/sih_top_tb.sv
// self-checking bench for the status interrupt hierarchy
`timescale 1ns/1ps
module sih_top_tb;
   logic                  clk = 1'b0;
   logic                  rst_n = 1'b0;
   logic                  srw = 1'b0;
   logic                  srv = 1'b0;
   logic                  sync_loss = 1'b0;
   logic                  idle_sel = 1'b0;
   sih_pkg::sih_src_t     [3:0] src = '0;
   logic [3:0]            srd = '0;
   logic [3:0]            gen = '0;
   logic [3:0][7:0]       w1c = '0;
   logic [8:0][7:0]       xen = '0;
   logic [8:0][7:0]       xcnd = '0;
   logic [8:0][7:0]       xdbl = '0;
   logic                  xrst = 1'b0;
   sih_pkg::sih_xacc_t    acc;
   logic [3:0][7:0]       lat;
   logic [3:0]            gst;
   logic [7:0]            xrd, inf1, inf2;
   logic                  srst, irq_n, irq_oe;
   logic [7:0]            ref_lat [4] = '{default: 8'h00};
   logic [15:0]           seed = 16'h003d;
   int                    n_fail = 0;
   int                    total_checks = 0;
   int                    g, w;

   always #5 clk = ~clk;

   sih_top dut_u (.I_CORE_CLK(clk), .I_ARST_N(rst_n), .I_SOFT_RST_WR(srw),
      .I_SOFT_RST_VAL(srv), .I_XCVR_RST_PIN(xrst), .I_SRC(src), .I_SRC_RD(srd),
      .I_SRC_W1C(w1c), .I_GLOBAL_IRQ_ENABLE(gen), .I_IRQ_IDLE_DRIVE_SELECT(idle_sel),
      .I_XSR_EVENT('0), .I_XSR_COND(xcnd), .I_XSR_IS_COND('0), .I_XSR_DOUBLE(xdbl),
      .I_XSR_ENABLE(xen), .I_XACC(acc), .I_RX_SYNC_LOSS_FLAG(sync_loss),
      .O_SRC_LATCHED(lat), .O_GLOBAL_IRQ_STATUS(gst), .O_XSR_READ(xrd),
      .O_XCVR_IRQ_INFO_ONE(inf1), .O_XCVR_IRQ_INFO_TWO(inf2), .O_SOFT_RST(srst),
      .O_IRQ_N_OUT(irq_n), .O_IRQ_N_OE(irq_oe));

   sih_host_model host_u (.i_clk(clk), .o_acc(acc));

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // interrupt pin: driven low when active, idle drive per select
   task automatic chk_irq(input logic act);
      chk("irq enable", {7'h0, act | idle_sel}, {7'h0, irq_oe});
      if (irq_oe === 1'b1) chk("irq pin", {7'h0, ~act}, {7'h0, irq_n});
   endtask

   // global status first, then the latched registers; irq a cycle later
   task automatic chk_all;
      logic [3:0] gexp;
      // latched status masked by its enables
      for (int i = 0; i < 4; i++) begin
         gexp[i] = |(ref_lat[i] & src[i].enable);
      end
      chk("global status", {4'h0, gexp}, {4'h0, gst});
      for (int i = 0; i < 4; i++) begin
         chk("latched", ref_lat[i], lat[i]);
      end
      @(negedge clk);
      chk_irq(|(gexp & gen));
   endtask

   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (20) @(negedge clk);
      rst_n = 1'b1;
      chk("soft reset", 8'h00, {7'h0, srst});
      chk_irq(1'b0);
      // random events, enables, global enables, idle drive and clears
      for (int k = 0; k < 32; k++) begin
         seed = lfsr(seed);
         g = seed[1:0];
         src[g].set = seed[11:4];
         idle_sel = seed[2];
         gen = (k % 4 == 3) ? seed[15:12] : 4'hf;
         seed = lfsr(seed);
         src[g].enable = seed[7:0];
         ref_lat[g] = ref_lat[g] | src[g].set;
         @(negedge clk);
         src[g].set = 8'h00;
         chk_all();
         if (seed[8]) begin
            srd[g] = 1'b1;
            ref_lat[g] = 8'h00;
         end else begin
            w1c[g] = seed[15:8];
            ref_lat[g] = ref_lat[g] & ~seed[15:8];
         end
         @(negedge clk);
         srd = '0;
         w1c = '0;
         chk_all();
      end
      // soft reset sticks, silences the hierarchy, then a zero write clears it
      srw = 1'b1;
      srv = 1'b1;
      src[0].enable = 8'hff;
      @(negedge clk);
      srw = 1'b0;
      src[0].set = 8'h81;
      ref_lat = '{default: 8'h00};
      @(negedge clk);
      src[0].set = 8'h00;
      repeat (3) @(negedge clk);
      chk("soft reset", 8'h01, {7'h0, srst});
      chk_all();
      srw = 1'b1;
      srv = 1'b0;
      @(negedge clk);
      srw = 1'b0;
      @(negedge clk);
      chk("soft reset", 8'h00, {7'h0, srst});
      // recovery wait after the soft reset clears
      repeat (4) @(negedge clk);
      // loss of sync on the second transceiver register
      xen[1] = 8'h01;
      sync_loss = 1'b1;
      for (w = 0; w < 10 && inf1[1] !== 1'b1; w++) @(negedge clk);
      if (w == 10) begin
         n_fail++;
         $display("[FAIL] info one bit expected 1 seen %b", inf1[1]);
         stop_test();
      end
      chk("info one", 8'h02, inf1);
      chk("info two", 8'h00, inf2);
      @(negedge clk);
      chk_irq(1'b1);
      host_u.access(4'h1, 8'h01);
      chk("xsr read", 8'h01, xrd);
      host_u.access(4'h1, 8'h01);
      chk("xsr read", 8'h01, xrd);
      sync_loss = 1'b0;
      repeat (5) @(negedge clk);
      host_u.access(4'h1, 8'h10);
      chk("xsr read", 8'h11, xrd);
      host_u.access(4'h1, 8'h10);
      chk("xsr read", 8'h01, xrd);
      host_u.access(4'h1, 8'h01);
      chk("xsr read", 8'h01, xrd);
      host_u.access(4'h1, 8'h01);
      chk("xsr read", 8'h00, xrd);
      @(negedge clk);
      chk("info one", 8'h00, inf1);
      // double interrupt condition on register eight, bit two
      xen[8] = 8'h04;
      xdbl[8] = 8'h04;
      xcnd[8] = 8'h04;
      repeat (2) @(negedge clk);
      chk("info two", 8'h01, inf2);
      chk_irq(1'b1);
      // condition clears in the same cycle as the refresh write
      fork
         host_u.access(4'h8, 8'h04);
         begin
            @(negedge clk);
            xcnd[8] = 8'h00;
         end
      join
      chk("xsr read", 8'h04, xrd);
      host_u.access(4'h8, 8'h04);
      chk("xsr read", 8'h04, xrd);
      host_u.access(4'h8, 8'h04);
      chk("xsr read", 8'h00, xrd);
      // transceiver reset pin clears the registers and silences the pin
      xcnd[8] = 8'h04;
      repeat (2) @(negedge clk);
      chk_irq(1'b1);
      xrst = 1'b1;
      repeat (4) @(negedge clk);
      chk_irq(1'b0);
      chk("info two", 8'h00, inf2);
      xrst = 1'b0;
      // recovery wait after the transceiver reset
      repeat (4) @(negedge clk);
      chk("info two", 8'h01, inf2);
      stop_test();
   end
endmodule
